// ---- verilog/acc_pkg.sv ----
// Functional notes
// RULE1 - 24 or 48 machine cycles per conversion
// RULE2 - first 6 cycles sample, inside total
// RULE3 - channel bits pick input 0 to 3
// RULE4 - channel writes only when idle, clear
// RULE5 - result lands in result register
// RULE6 - starts never disturb running conversion
// RULE7 - starts while busy or done dropped
// RULE8 - result frozen while done set
// RULE9 - power-down aborts; done result survives
// RULE10 - pin start only when enable bit set
// RULE11 - start sets busy; zero write ignored
// RULE12 - done follows busy within one cycle
// RULE13 - done raises interrupt; software clears only
// RULE14 - reference-off bit turns ladder off
// RULE15 - done set for every start method
// RULE16 - control runs on during idle
// RULE17 - pin synchronised, rising edge one request
package acc_pkg;
  localparam logic [7:0] ADDR_CONTROL   = 8'hc4;
  localparam logic [7:0] ADDR_RESULT    = 8'hc5;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'hc6;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'hc7;
  localparam int BIT_REF_OFF  = 6;
  localparam int BIT_EXT_EN   = 5;
  localparam int BIT_DONE     = 4;
  localparam int BIT_BUSY     = 3;
  localparam int BIT_TIME_SEL = 2;
  localparam int BIT_CH_HI    = 1;
  localparam int BIT_CH_LO    = 0;
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_RESULT  = 8'h00;
  localparam logic [7:0] RESET_MASK    = 8'h00;
  localparam logic [3:0] MC_CLOCKS     = 4'd12;
  localparam logic [5:0] CONV_SHORT_MC = 6'd24;
  localparam logic [5:0] CONV_LONG_MC  = 6'd48;
  localparam logic [5:0] SAMPLE_MC     = 6'd6;
  typedef enum logic [1:0] {ACC_IDLE, ACC_SAMPLE, ACC_CONVERT} acc_state_e;
endpackage : acc_pkg

// ---- verilog/acc_ctrl.sv ----
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module acc_ctrl (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic       ext_start_pin,
  input  wire logic       power_down_request,
  input  wire logic       sleep_light_request,
  input  wire logic [7:0] core_result,
  output logic      [1:0] mux_select,
  output logic            sample_en,
  output logic            convert_en,
  output logic            reference_off,
  output logic            irq
);
  typedef struct packed {
    acc_pkg::acc_state_e st;
    logic [3:0] osc_cnt;
    logic [5:0] mc_cnt;
    logic       ref_off;
    logic       ext_en;
    logic       done;
    logic       busy;
    logic       time_sel;
    logic [1:0] chan;
    logic [7:0] result;
    logic       irq_mask;
    logic       pin_s1;
    logic       pin_s2;
    logic       pin_s3;
    logic       pd_s1;
    logic       pd_s2;
    logic [7:0] rdata;
    logic       irq;
    logic       sample_en;
    logic       convert_en;
  } acc_s;
  acc_s q_reg;
  acc_s q_next;

  function automatic logic [7:0] ctl_view(input acc_s s);
    ctl_view = {1'b0, s.ref_off, s.ext_en, s.done, s.busy, s.time_sel, s.chan};
  endfunction : ctl_view

  logic mc_tick;
  logic pin_rise;
  logic conv_end;
  logic [5:0] total_mc;
  assign mc_tick  = (q_reg.osc_cnt == acc_pkg::MC_CLOCKS - 4'd1);
  assign pin_rise = q_reg.pin_s2 & ~q_reg.pin_s3; // [RULE17]
  assign total_mc = q_reg.time_sel ? acc_pkg::CONV_LONG_MC : acc_pkg::CONV_SHORT_MC; // [RULE1]
  assign conv_end = (q_reg.st == acc_pkg::ACC_CONVERT) && mc_tick
                    && (q_reg.mc_cnt == total_mc - 6'd1);

  // sleep_light_request is not consulted: the sequencer keeps the same clock in idle
  always_comb begin
    logic sw_start;
    logic wr_ctl;
    logic idle_ok;
    q_next   = q_reg;
    sw_start = 1'b0;
    wr_ctl   = wr_stb && (addr == acc_pkg::ADDR_CONTROL);
    idle_ok  = ~q_reg.busy & ~q_reg.done;
    q_next.pin_s1 = ext_start_pin;
    q_next.pin_s2 = q_reg.pin_s1;
    q_next.pin_s3 = q_reg.pin_s2;
    q_next.pd_s1  = power_down_request;
    q_next.pd_s2  = q_reg.pd_s1;
    // machine cycle prescaler, free running including idle
    q_next.osc_cnt = mc_tick ? 4'd0 : q_reg.osc_cnt + 4'd1; // [RULE16]
    if (wr_ctl) begin
      q_next.ref_off  = wdata[acc_pkg::BIT_REF_OFF]; // [RULE14]
      q_next.ext_en   = wdata[acc_pkg::BIT_EXT_EN];
      q_next.time_sel = wdata[acc_pkg::BIT_TIME_SEL];
      if (idle_ok) begin
        q_next.chan = {wdata[acc_pkg::BIT_CH_HI], wdata[acc_pkg::BIT_CH_LO]}; // [RULE4]
      end
      if (!wdata[acc_pkg::BIT_DONE]) begin
        q_next.done = 1'b0; // [RULE13]
      end
      sw_start = wdata[acc_pkg::BIT_BUSY]; // zero write ignored [RULE11]
    end
    if (wr_stb && addr == acc_pkg::ADDR_IRQ_STAT && wdata[acc_pkg::BIT_DONE]) begin
      q_next.done = 1'b0; // write-one-clear alias
    end
    if (wr_stb && addr == acc_pkg::ADDR_IRQ_MASK) begin
      q_next.irq_mask = wdata[acc_pkg::BIT_DONE];
    end
    // sequencer
    case (q_reg.st)
      acc_pkg::ACC_IDLE: begin
        // starts are taken only when neither flag is set; others are lost
        if (idle_ok && !q_reg.pd_s2
            && (sw_start || (pin_rise && q_reg.ext_en))) begin // [RULE7] [RULE10]
          q_next.st      = acc_pkg::ACC_SAMPLE;
          q_next.busy    = 1'b1; // [RULE11]
          q_next.mc_cnt  = 6'd0;
          q_next.osc_cnt = 4'd0;
        end
      end
      acc_pkg::ACC_SAMPLE: begin
        if (mc_tick) begin
          q_next.mc_cnt = q_reg.mc_cnt + 6'd1;
          if (q_reg.mc_cnt == acc_pkg::SAMPLE_MC - 6'd1) begin
            q_next.st = acc_pkg::ACC_CONVERT; // [RULE2]
          end
        end
      end
      acc_pkg::ACC_CONVERT: begin
        if (mc_tick) begin
          q_next.mc_cnt = q_reg.mc_cnt + 6'd1;
        end
        if (conv_end) begin
          q_next.st     = acc_pkg::ACC_IDLE;
          q_next.busy   = 1'b0; // [RULE12]
          q_next.done   = 1'b1; // set beats clear [RULE15] [RULE13]
          q_next.result = core_result; // [RULE5]
        end
      end
      default: begin
        q_next.st = acc_pkg::ACC_IDLE;
      end
    endcase
    // running conversion ignores starts; power-down aborts it only [RULE6] [RULE9]
    // an abort on the last cycle must not slip a half result in as done
    if (q_reg.pd_s2 && q_reg.st != acc_pkg::ACC_IDLE) begin
      q_next.st     = acc_pkg::ACC_IDLE;
      q_next.busy   = 1'b0;
      q_next.done   = q_reg.done; // [RULE9]
      q_next.result = q_reg.result;
    end
    q_next.sample_en  = (q_next.st == acc_pkg::ACC_SAMPLE);
    q_next.convert_en = (q_next.st == acc_pkg::ACC_CONVERT);
    q_next.irq        = q_next.done & q_next.irq_mask; // [RULE13]
    // read data one cycle after the strobe
    q_next.rdata = 8'h00;
    if (rd_stb) begin
      case (addr)
        acc_pkg::ADDR_CONTROL:  q_next.rdata = ctl_view(q_reg);
        acc_pkg::ADDR_RESULT:   q_next.rdata = q_reg.result;
        acc_pkg::ADDR_IRQ_STAT: q_next.rdata = {3'b000, q_reg.done, 4'h0};
        acc_pkg::ADDR_IRQ_MASK: q_next.rdata = {3'b000, q_reg.irq_mask, 4'h0};
        default:                q_next.rdata = 8'h00;
      endcase
    end
  end

  // whole state in one register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign rdata         = q_reg.rdata;
  assign mux_select    = q_reg.chan; // [RULE3]
  assign sample_en     = q_reg.sample_en;
  assign convert_en    = q_reg.convert_en;
  assign reference_off = q_reg.ref_off;
  assign irq           = q_reg.irq;

  property p_len;
    @(posedge clk) disable iff (!rst_b)
      $rose(q_reg.busy) && !q_reg.time_sel && !q_reg.pd_s2 ##1 !q_reg.pd_s2 [*8]
      |-> q_reg.busy;
  endproperty
  a_len: assert property (p_len) else $error("conversion ended early"); // [RULE1]

  // length of each busy spell, so the full count is checked where it ends
  logic [9:0] busy_len_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_len_reg <= 10'h000;
    end else if (q_reg.busy) begin
      busy_len_reg <= busy_len_reg + 10'h001;
    end else begin
      busy_len_reg <= 10'h000;
    end
  end

  property p_full_len;
    @(posedge clk) disable iff (!rst_b)
      conv_end && !q_reg.pd_s2 |-> busy_len_reg == (q_reg.time_sel
        ? 10'(acc_pkg::CONV_LONG_MC) * 10'(acc_pkg::MC_CLOCKS) - 10'h001
        : 10'(acc_pkg::CONV_SHORT_MC) * 10'(acc_pkg::MC_CLOCKS) - 10'h001);
  endproperty
  a_full_len: assert property (p_full_len) else $error("conversion length wrong"); // [RULE1]

  property p_sample;
    @(posedge clk) disable iff (!rst_b)
      $rose(q_reg.busy) && !q_reg.pd_s2 |-> ##[71:73] q_reg.st == acc_pkg::ACC_CONVERT
      || q_reg.pd_s2 || !q_reg.busy;
  endproperty
  a_sample: assert property (p_sample) else $error("sampling length wrong"); // [RULE2]

  property p_chan;
    @(posedge clk) disable iff (!rst_b)
      (q_reg.busy || q_reg.done) |=> $stable(q_reg.chan);
  endproperty
  a_chan: assert property (p_chan) else $error("channel changed while locked"); // [RULE4]

  property p_hold;
    @(posedge clk) disable iff (!rst_b)
      q_reg.done |=> $stable(q_reg.result);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed while done"); // [RULE8]

  property p_block;
    @(posedge clk) disable iff (!rst_b)
      (q_reg.busy || q_reg.done) && q_reg.st == acc_pkg::ACC_IDLE |=> !$rose(q_reg.busy);
  endproperty
  a_block: assert property (p_block) else $error("start accepted while blocked"); // [RULE7]

  property p_ext;
    @(posedge clk) disable iff (!rst_b)
      !q_reg.ext_en && !wr_stb |=> !$rose(q_reg.busy);
  endproperty
  a_ext: assert property (p_ext) else $error("pin start while disabled"); // [RULE10]

  property p_done;
    @(posedge clk) disable iff (!rst_b)
      conv_end && !q_reg.pd_s2 |=> q_reg.done && !q_reg.busy;
  endproperty
  a_done: assert property (p_done) else $error("completion flags wrong"); // [RULE12]

  property p_irq;
    @(posedge clk) disable iff (!rst_b)
      q_reg.done && q_reg.irq_mask |=> irq || !q_reg.done || !q_reg.irq_mask;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing"); // [RULE13]

  property p_abort;
    @(posedge clk) disable iff (!rst_b)
      q_reg.pd_s2 && q_reg.st != acc_pkg::ACC_IDLE |=> !q_reg.busy && $stable(q_reg.done);
  endproperty
  a_abort: assert property (p_abort) else $error("power-down abort wrong"); // [RULE9]

  property p_ref;
    @(posedge clk) disable iff (!rst_b)
      wr_stb && addr == acc_pkg::ADDR_CONTROL |=> reference_off == $past(wdata[6]);
  endproperty
  a_ref: assert property (p_ref) else $error("reference bit not applied"); // [RULE14]
endmodule : acc_ctrl

// ---- tb/acc_core_model.sv ----
`timescale 1ns/1ps
module acc_core_model (
  input  wire logic       clk,
  input  wire logic [1:0] mux_select,
  input  wire logic       sample_en,
  input  wire logic       convert_en,
  input  wire logic [7:0] level,
  output logic      [7:0] core_result
);
  logic [7:0] held_reg;
  logic [7:0] junk_reg = 8'h5a;
  // the input seen while sampling is what gets converted
  always @(posedge clk) begin
    junk_reg <= junk_reg + 8'h35;
    if (sample_en === 1'b1) held_reg <= level + {6'h00, mux_select};
  end
  // outside a conversion the code lines wander, so a late capture shows up
  assign core_result = (sample_en | convert_en) ? held_reg : junk_reg;
endmodule : acc_core_model

// ---- tb/adc_conversion_control_tb_top.sv ----
`timescale 1ns/1ps
module adc_conversion_control_tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [7:0]  rdata;
  logic        ext_start_pin = 1'b0;
  logic        power_down_request = 1'b0;
  logic        sleep_light_request = 1'b0;
  logic [7:0]  core_result;
  logic [1:0]  mux_select;
  logic        sample_en;
  logic        convert_en;
  logic        reference_off;
  logic        irq;
  logic [7:0]  level = 8'h00;
  logic [15:0] n_samp = 16'h0000;
  logic [15:0] n_act = 16'h0000;
  int          n_fail = 0;
  int          checked = 0;
  int          seed = 32'h9704_cf86;
  logic [8:0]  tbl [4] = '{9'h000, 9'h007, 9'h041, 9'h122};
  always #12.5 clk = ~clk;
  acc_ctrl u_acc_ctrl (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .ext_start_pin(ext_start_pin),
    .power_down_request(power_down_request), .sleep_light_request(sleep_light_request),
    .core_result(core_result), .mux_select(mux_select), .sample_en(sample_en),
    .convert_en(convert_en), .reference_off(reference_off), .irq(irq));
  acc_core_model u_acc_core_model (.clk(clk), .mux_select(mux_select), .sample_en(sample_en),
    .convert_en(convert_en), .level(level), .core_result(core_result));
  // phase counters, cleared by the sequence before each start
  always @(posedge clk) begin
    if (sample_en === 1'b1) n_samp <= n_samp + 16'h0001;
    if ((sample_en | convert_en) === 1'b1) n_act <= n_act + 16'h0001;
  end
  task chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // pin held several cycles so the synchroniser sees one clean rise
  task pulse;
    @(posedge clk);
    ext_start_pin <= 1'b1;
    repeat (4) @(posedge clk);
    ext_start_pin <= 1'b0;
  endtask : pulse
  task run(input logic [7:0] ctl, input logic pin);
    int         g;
    logic [7:0] d;
    logic [15:0] len;
    len = ctl[2] ? 16'h0240 : 16'h0120;
    sleep_light_request <= 1'($random(seed));
    n_samp = 16'h0000;
    n_act = 16'h0000;
    if (pin) begin
      wr(acc_pkg::ADDR_CONTROL, ctl);
      pulse();
    end else begin
      wr(acc_pkg::ADDR_CONTROL, ctl | 8'h08);
    end
    wr(acc_pkg::ADDR_CONTROL, ctl ^ 8'h0b);
    for (g = 0; g < 700 && (n_act == 0 || (sample_en | convert_en) === 1'b1); g++) @(posedge clk);
    wr(acc_pkg::ADDR_CONTROL, ctl ^ 8'h1b);
    repeat (8) @(posedge clk);
    #1 chk(n_samp, 16'h0048);
    chk(n_act, len);
    chk(16'(mux_select), 16'(ctl[1:0]));
    chk(16'(reference_off), 16'(ctl[6]));
    chk(16'(irq), 16'h0001);
    rd(acc_pkg::ADDR_CONTROL, d);
    chk(16'(d), 16'((ctl & 8'h67) | 8'h10));
    power_down_request <= 1'b1;
    repeat (4) @(posedge clk);
    rd(acc_pkg::ADDR_RESULT, d);
    chk(16'(d), 16'(8'(level + {6'h00, ctl[1:0]})));
    chk(16'(irq), 16'h0001);
    power_down_request <= 1'b0;
    wr(acc_pkg::ADDR_IRQ_STAT, 8'h10);
    repeat (3) @(posedge clk);
    #1 chk(16'(irq), 16'h0000);
  endtask : run
  task summarize;
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  initial begin
    #(25 * 20000);
    n_fail++;
    summarize();
  end
  initial begin
    logic [7:0] d;
    level = 8'($random(seed));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd(acc_pkg::ADDR_CONTROL, d);
    chk(16'(d), 16'(acc_pkg::RESET_CONTROL));
    rd(8'h3f, d);
    chk(16'(d), 16'h0000);
    wr(acc_pkg::ADDR_IRQ_MASK, 8'h10);
    for (int i = 0; i < 7; i++) begin
      if (i < 4) run(tbl[i][7:0], tbl[i][8]);
      else run(8'($random(seed)) & 8'h47, 1'b0);
    end
    // pin ignored while external start is disabled
    wr(acc_pkg::ADDR_CONTROL, 8'h00);
    n_act = 16'h0000;
    pulse();
    repeat (10) @(posedge clk);
    chk(n_act, 16'h0000);
    // power-down in mid-conversion aborts without a result
    wr(acc_pkg::ADDR_CONTROL, 8'h08);
    repeat (100) @(posedge clk);
    power_down_request <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk(16'(sample_en | convert_en), 16'h0000);
    rd(acc_pkg::ADDR_CONTROL, d);
    chk(16'(d & 8'h18), 16'h0000);
    power_down_request <= 1'b0;
    summarize();
  end
endmodule : adc_conversion_control_tb_top
